// *** crf_pkg.sv ***
// shared constants, widths and helpers for the processor register file
package crf_pkg;
	localparam int          XLEN         = 64;
	localparam int          AW           = 5;
	localparam int          NREG         = 32;
	localparam int          FCR_W        = 32;
	localparam int          EXP_W        = 12;
	localparam int          BOFF_W       = 16;
	localparam logic [4:0]  ZERO_INDEX   = 5'h00;
	localparam logic [4:0]  LINK_INDEX   = 5'h1F;
	localparam logic [63:0] PC_STEP      = 64'h0000_0000_0000_0004;
	localparam logic [63:0] LINK_OFFSET  = 64'h0000_0000_0000_0008;
	localparam logic [63:0] PC_RESET     = 64'h0000_0000_0000_0000;
	localparam logic [63:0] DATA_RESET   = 64'h0000_0000_0000_0000;
	localparam int          EXP_LSB      = 52;
	localparam int          EXP_MSB      = 62;
	// arbitrary identification value
	localparam logic [31:0] FPU_ID_VALUE = 32'h0000_0100;
	localparam logic [31:0] FCSR_RESET   = 32'h0000_0000;
	localparam logic [31:0] FCSR_WMASK   = 32'h01FF_FFFF;

	// in 32-bit mode a value is the sign extension of its low word
	function automatic logic [63:0] fit_mode(input logic [63:0] d, input logic mode64);
		fit_mode = mode64 ? d : {{32{d[31]}}, d[31:0]};
	endfunction : fit_mode
endpackage : crf_pkg

// *** crf_regmem.sv ***
// 32 x 64 register array, two registered read ports and one write port
`timescale 1ns/100ps
module crf_regmem #(
	parameter bit HARD_ZERO = 1'b0
) (
	input  wire logic        mclk,     // pipeline clock
	input  wire logic        reset,    // synchronous, active high
	input  wire logic        we,       // write strobe
	input  wire logic [4:0]  waddr,    // write index
	input  wire logic [63:0] wdata,    // write data
	input  wire logic [4:0]  raddr_a,  // read index, port a
	input  wire logic [4:0]  raddr_b,  // read index, port b
	output logic      [63:0] rdata_a,  // read data, port a
	output logic      [63:0] rdata_b   // read data, port b
);
	logic [63:0] mem [0:crf_pkg::NREG-1];
	logic [63:0] next_rdata_a;
	logic [63:0] next_rdata_b;
	logic        wr_ok;

	////////////////////////////////////////////////////////////////////////////
	// write is dropped on index zero when it is hardwired
	always_comb
	begin
		wr_ok = we && !(HARD_ZERO && waddr == crf_pkg::ZERO_INDEX); // RL3
		next_rdata_a = (wr_ok && waddr == raddr_a) ? wdata : mem[raddr_a];
		next_rdata_b = (wr_ok && waddr == raddr_b) ? wdata : mem[raddr_b];
		if (HARD_ZERO && raddr_a == crf_pkg::ZERO_INDEX)
		begin
			next_rdata_a = crf_pkg::DATA_RESET; // RL4
		end
		if (HARD_ZERO && raddr_b == crf_pkg::ZERO_INDEX)
		begin
			next_rdata_b = crf_pkg::DATA_RESET; // RL4
		end
	end

	// two reads and one write per cycle, write lands at the edge
	always_ff @(posedge mclk)
	begin
		if (wr_ok)
		begin
			mem[waddr] <= wdata; // RL16
		end
		if (reset)
		begin
			rdata_a <= crf_pkg::DATA_RESET;
			rdata_b <= crf_pkg::DATA_RESET;
		end
		else
		begin
			rdata_a <= next_rdata_a; // RL16
			rdata_b <= next_rdata_b;
		end
	end
endmodule : crf_regmem

// *** crf_core.sv ***
// architectural register set: general, float, pc, product halves, link flag, fpu control
// How it works
// (RL1) thirty-two general registers of 64 bits, read and written as operands.
// (RL2) a separate set of thirty-two 64-bit float registers.
// (RL3) general register zero reads zero; writes to it are thrown away.
// (RL4) register zero serves as a constant-zero source operand.
// (RL5) jump-and-link forms write the return address into register 31.
// (RL6) a 64-bit program counter holds the fetch address.
// (RL7) next fetch picks incremented pc, branch adder result or jump target.
// (RL8) upper product register takes the high doubleword of multiply and divide.
// (RL9) bottom product register takes the low doubleword of multiply and divide.
// (RL10) a one-bit load-link flag tracks linked load and store-conditional.
// (RL11) a 32-bit float implementation and revision register identifies the fpu.
// (RL12) a 32-bit float control and status register holds settings and status.
// (RL13) general, pc and product registers act as 32-bit or 64-bit depending on the operating mode.
// (RL14) datapath is 64 bits for integers and mantissas, 12 for exponents.
// (RL15) no status word register here; status lives in the system coprocessor.
// (RL16) general array gives two reads and one write per cycle.
`timescale 1ns/100ps
module crf_core (
	input  wire logic        mclk,          // pipeline clock, 250 MHz
	input  wire logic        reset,         // synchronous, active high
	input  wire logic        mode64,        // 1: 64-bit mode, 0: 32-bit mode
	input  wire logic [4:0]  gp_raddr_a,    // general read index a
	input  wire logic [4:0]  gp_raddr_b,    // general read index b
	output logic      [63:0] gp_rdata_a,    // general read data a
	output logic      [63:0] gp_rdata_b,    // general read data b
	input  wire logic        gp_we,         // general write strobe
	input  wire logic [4:0]  gp_waddr,      // general write index
	input  wire logic [63:0] gp_wdata,      // general write data
	input  wire logic        link_we,       // jump-and-link: write return address
	input  wire logic [4:0]  fp_raddr_a,    // float read index a
	input  wire logic [4:0]  fp_raddr_b,    // float read index b
	output logic      [63:0] fp_rdata_a,    // float read data a
	output logic      [63:0] fp_rdata_b,    // float read data b
	output logic      [11:0] fp_exp_a,      // exponent of float read a, one cycle later
	input  wire logic        fp_we,         // float write strobe
	input  wire logic [4:0]  fp_waddr,      // float write index
	input  wire logic [63:0] fp_wdata,      // float write data
	input  wire logic        pc_advance,    // step the program counter
	input  wire logic        branch_taken,  // conditional branch resolved taken
	input  wire logic [15:0] branch_offset, // branch word offset
	input  wire logic        jump_taken,    // jump to absolute target
	input  wire logic [63:0] jump_target,   // jump target address
	output logic      [63:0] pc,            // fetch address
	input  wire logic        upper_we,      // upper product write
	input  wire logic [63:0] upper_wdata,   // upper product data
	input  wire logic        bottom_we,     // bottom product write
	input  wire logic [63:0] bottom_wdata,  // bottom product data
	output logic      [63:0] product_upper_half,  // upper product register
	output logic      [63:0] product_bottom_half, // bottom product register
	input  wire logic        ll_set,        // linked load executed
	input  wire logic        ll_clear,      // link broken
	output logic             load_link_flag, // load-link flag
	input  wire logic        fcsr_we,       // control/status write
	input  wire logic [31:0] fcsr_wdata,    // control/status write data
	input  wire logic [31:0] fcsr_hw_set,   // status bits set by the fpu
	output logic      [31:0] float_impl_revision_reg,  // implementation/revision
	output logic      [31:0] float_control_status_reg  // control/status
);
	logic [63:0] ret_addr;
	logic [63:0] gp_w_data;
	logic [4:0]  gp_w_addr;
	logic        gp_w_en;
	logic [63:0] branch_target;
	logic [63:0] next_pc;
	logic [63:0] next_upper;
	logic [63:0] next_bottom;
	logic        next_ll;
	logic [31:0] next_fcsr;
	logic [11:0] next_exp;

	////////////////////////////////////////////////////////////////////////////
	// general write port: link write overrides an ordinary write
	always_comb
	begin
		ret_addr  = crf_pkg::fit_mode(pc + crf_pkg::LINK_OFFSET, mode64);
		gp_w_en   = gp_we || link_we;
		gp_w_addr = link_we ? crf_pkg::LINK_INDEX : gp_waddr; // RL5
		gp_w_data = link_we ? ret_addr : crf_pkg::fit_mode(gp_wdata, mode64); // RL13
	end

	crf_regmem #(.HARD_ZERO(1'b1)) u_general_register_array ( // RL1
		.mclk    (mclk),
		.reset   (reset),
		.we      (gp_w_en),
		.waddr   (gp_w_addr),
		.wdata   (gp_w_data),
		.raddr_a (gp_raddr_a),
		.raddr_b (gp_raddr_b),
		.rdata_a (gp_rdata_a),
		.rdata_b (gp_rdata_b)
	);

	// float array keeps index zero writable
	crf_regmem #(.HARD_ZERO(1'b0)) u_float_register_array ( // RL2
		.mclk    (mclk),
		.reset   (reset),
		.we      (fp_we),
		.waddr   (fp_waddr),
		.wdata   (fp_wdata),
		.raddr_a (fp_raddr_a),
		.raddr_b (fp_raddr_b),
		.rdata_a (fp_rdata_a),
		.rdata_b (fp_rdata_b)
	);

	////////////////////////////////////////////////////////////////////////////
	// next fetch address: jump over branch over increment
	always_comb
	begin
		branch_target = pc + crf_pkg::PC_STEP
			+ {{46{branch_offset[15]}}, branch_offset, 2'b00}; // RL7
		next_pc = pc;
		if (pc_advance)
		begin
			if (jump_taken)
			begin
				next_pc = crf_pkg::fit_mode(jump_target, mode64); // RL7
			end
			else if (branch_taken)
			begin
				next_pc = crf_pkg::fit_mode(branch_target, mode64); // RL7
			end
			else
			begin
				next_pc = crf_pkg::fit_mode(pc + crf_pkg::PC_STEP, mode64); // RL7
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			pc <= crf_pkg::PC_RESET;
		end
		else
		begin
			pc <= next_pc; // RL6
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// special registers; status and cause live in the system control coprocessor // RL15
	always_comb
	begin
		next_upper  = upper_we ? crf_pkg::fit_mode(upper_wdata, mode64)
			: product_upper_half; // RL8
		next_bottom = bottom_we ? crf_pkg::fit_mode(bottom_wdata, mode64)
			: product_bottom_half; // RL9
		next_ll   = ll_set ? 1'b1 : (ll_clear ? 1'b0 : load_link_flag); // RL10
		next_fcsr = float_control_status_reg;
		if (fcsr_we)
		begin
			next_fcsr = fcsr_wdata & crf_pkg::FCSR_WMASK;
		end
		next_fcsr = next_fcsr | fcsr_hw_set; // RL12
		next_exp  = {1'b0, fp_rdata_a[crf_pkg::EXP_MSB:crf_pkg::EXP_LSB]}; // RL14
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			product_upper_half       <= crf_pkg::DATA_RESET;
			product_bottom_half      <= crf_pkg::DATA_RESET;
			load_link_flag           <= 1'b0;
			float_control_status_reg <= crf_pkg::FCSR_RESET;
			float_impl_revision_reg  <= crf_pkg::FPU_ID_VALUE;
			fp_exp_a                 <= 12'h000;
		end
		else
		begin
			product_upper_half       <= next_upper;
			product_bottom_half      <= next_bottom;
			load_link_flag           <= next_ll;
			float_control_status_reg <= next_fcsr;
			float_impl_revision_reg  <= crf_pkg::FPU_ID_VALUE; // RL11
			fp_exp_a                 <= next_exp;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	AST_ZERO_READ: assert property (@(posedge mclk) disable iff (reset) // RL3
		gp_raddr_a == crf_pkg::ZERO_INDEX |=> gp_rdata_a == 64'h0)
		else $error("register zero read nonzero");
	AST_ZERO_SRC_B: assert property (@(posedge mclk) disable iff (reset) // RL4
		gp_raddr_b == crf_pkg::ZERO_INDEX |=> gp_rdata_b == 64'h0)
		else $error("zero source on port b nonzero");
	AST_LINK_WRITE: assert property (@(posedge mclk) disable iff (reset) // RL5
		(link_we ##1 (gp_raddr_a == 5'h1F && !link_we && !gp_we))
		|=> gp_rdata_a == $past(ret_addr, 2))
		else $error("link register missed return address");
	AST_PC_STEP: assert property (@(posedge mclk) disable iff (reset) // RL7
		pc_advance && !jump_taken && !branch_taken && mode64
		|=> pc == $past(pc) + 64'h4)
		else $error("pc did not step by four");
	AST_PC_HOLD: assert property (@(posedge mclk) disable iff (reset) // RL6
		!pc_advance |=> $stable(pc))
		else $error("pc moved without advance");
	AST_PC_JUMP: assert property (@(posedge mclk) disable iff (reset) // RL7
		pc_advance && jump_taken && mode64 |=> pc == $past(jump_target))
		else $error("jump target not taken");
	AST_UPPER_WRITE: assert property (@(posedge mclk) disable iff (reset) // RL8
		upper_we && mode64 |=> product_upper_half == $past(upper_wdata))
		else $error("upper product not written");
	AST_BOTTOM_WRITE: assert property (@(posedge mclk) disable iff (reset) // RL9
		bottom_we && mode64 |=> product_bottom_half == $past(bottom_wdata))
		else $error("bottom product not written");
	AST_LL_SET_WINS: assert property (@(posedge mclk) disable iff (reset) // RL10
		ll_set |=> load_link_flag)
		else $error("link flag not set");
	AST_LL_CLEAR: assert property (@(posedge mclk) disable iff (reset) // RL10
		ll_clear && !ll_set |=> !load_link_flag)
		else $error("link flag not cleared");
	AST_FPU_ID_CONST: assert property (@(posedge mclk) disable iff (reset) // RL11
		float_impl_revision_reg == crf_pkg::FPU_ID_VALUE)
		else $error("implementation register changed");
	AST_FCSR_WRITE: assert property (@(posedge mclk) disable iff (reset) // RL12
		fcsr_we && fcsr_hw_set == 32'h0
		|=> float_control_status_reg == ($past(fcsr_wdata) & 32'h01FF_FFFF))
		else $error("control status write lost");
	AST_MODE32_EXT: assert property (@(posedge mclk) disable iff (reset) // RL13
		upper_we && !mode64 |=> product_upper_half[63:32] == {32{product_upper_half[31]}})
		else $error("32-bit mode value not sign extended");
	AST_FP_ZERO_WR: assert property (@(posedge mclk) disable iff (reset) // RL2
		(fp_we && fp_waddr == 5'h00 ##1 (fp_raddr_a == 5'h00 && !fp_we))
		|=> fp_rdata_a == $past(fp_wdata, 2))
		else $error("float register zero not writable");
	AST_EXP_FIELD: assert property (@(posedge mclk) disable iff (reset) // RL14
		1'b1 |=> fp_exp_a == {1'b0, $past(fp_rdata_a[62:52])})
		else $error("exponent field wrong");

	COV_LINK: cover property (@(posedge mclk) disable iff (reset) link_we && jump_taken);
	COV_BRANCH: cover property (@(posedge mclk) disable iff (reset) pc_advance && branch_taken);
	COV_LL_BOTH: cover property (@(posedge mclk) disable iff (reset) ll_set && ll_clear);
	COV_FCSR: cover property (@(posedge mclk) disable iff (reset) fcsr_we && |fcsr_hw_set);
endmodule : crf_core

// *** crf_pipe_model.sv ***
// pipeline-side model driving the general register operand ports
`timescale 1ns/100ps
module crf_pipe_model (
	input  wire logic        mclk,       // pipeline clock
	output logic      [4:0]  gp_raddr_a, // read index a
	output logic      [4:0]  gp_raddr_b, // read index b
	input  wire logic [63:0] gp_rdata_a, // read data a
	input  wire logic [63:0] gp_rdata_b, // read data b
	output logic             gp_we,      // write strobe
	output logic      [4:0]  gp_waddr,   // write index
	output logic      [63:0] gp_wdata    // write data
);
	initial
	begin
		{gp_raddr_a, gp_raddr_b, gp_we, gp_waddr, gp_wdata} = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// write after gap idle cycles, read the same index at that edge
	task automatic wr(input logic [4:0] idx, input logic [63:0] d, input int gap,
		output logic [63:0] byp);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		{gp_we, gp_waddr, gp_wdata, gp_raddr_a} <= {1'b1, idx, d, idx};
		@(posedge mclk);
		gp_we <= 1'b0;
		// released data line must not keep its last value
		gp_wdata <= ~d;
		#1;
		byp = gp_rdata_a;
	endtask : wr

	// read both ports, indexes scrambled once taken
	task automatic rd(input logic [4:0] ia, ib, output logic [63:0] a, b);
		@(posedge mclk);
		{gp_raddr_a, gp_raddr_b} <= {ia, ib};
		@(posedge mclk);
		{gp_raddr_a, gp_raddr_b} <= {~ia, ~ib};
		#1;
		a = gp_rdata_a;
		b = gp_rdata_b;
	endtask : rd
endmodule : crf_pipe_model

// *** crf_core_tb_top.sv ***
// self-checking bench for the processor register file
`timescale 1ns/100ps
module crf_core_tb_top;
	logic        mclk = 1'b0;
	logic        reset, mode64, gp_we, link_we, fp_we, pc_advance, branch_taken, jump_taken;
	logic        upper_we, bottom_we, ll_set, ll_clear, fcsr_we, load_link_flag;
	logic [4:0]  gp_raddr_a, gp_raddr_b, gp_waddr, fp_raddr_a, fp_raddr_b, fp_waddr;
	logic [11:0] fp_exp_a;
	logic [15:0] branch_offset;
	logic [31:0] fcsr_wdata, fcsr_hw_set, float_impl_revision_reg, float_control_status_reg;
	logic [63:0] gp_rdata_a, gp_rdata_b, gp_wdata, fp_rdata_a, fp_rdata_b, fp_wdata, pc;
	logic [63:0] jump_target, upper_wdata, bottom_wdata, product_upper_half, product_bottom_half;
	logic [63:0] ra, rb;
	int          num_errors = 0;
	int          n_tests = 0;
	int          cycles = 0;

	crf_core DUT (
		.mclk                     (mclk),
		.reset                    (reset),
		.mode64                   (mode64),
		.gp_raddr_a               (gp_raddr_a),
		.gp_raddr_b               (gp_raddr_b),
		.gp_rdata_a               (gp_rdata_a),
		.gp_rdata_b               (gp_rdata_b),
		.gp_we                    (gp_we),
		.gp_waddr                 (gp_waddr),
		.gp_wdata                 (gp_wdata),
		.link_we                  (link_we),
		.fp_raddr_a               (fp_raddr_a),
		.fp_raddr_b               (fp_raddr_b),
		.fp_rdata_a               (fp_rdata_a),
		.fp_rdata_b               (fp_rdata_b),
		.fp_exp_a                 (fp_exp_a),
		.fp_we                    (fp_we),
		.fp_waddr                 (fp_waddr),
		.fp_wdata                 (fp_wdata),
		.pc_advance               (pc_advance),
		.branch_taken             (branch_taken),
		.branch_offset            (branch_offset),
		.jump_taken               (jump_taken),
		.jump_target              (jump_target),
		.pc                       (pc),
		.upper_we                 (upper_we),
		.upper_wdata              (upper_wdata),
		.bottom_we                (bottom_we),
		.bottom_wdata             (bottom_wdata),
		.product_upper_half       (product_upper_half),
		.product_bottom_half      (product_bottom_half),
		.ll_set                   (ll_set),
		.ll_clear                 (ll_clear),
		.load_link_flag           (load_link_flag),
		.fcsr_we                  (fcsr_we),
		.fcsr_wdata               (fcsr_wdata),
		.fcsr_hw_set              (fcsr_hw_set),
		.float_impl_revision_reg  (float_impl_revision_reg),
		.float_control_status_reg (float_control_status_reg)
	);
	crf_pipe_model pipe (
		.mclk       (mclk),
		.gp_raddr_a (gp_raddr_a),
		.gp_raddr_b (gp_raddr_b),
		.gp_rdata_a (gp_rdata_a),
		.gp_rdata_b (gp_rdata_b),
		.gp_we      (gp_we),
		.gp_waddr   (gp_waddr),
		.gp_wdata   (gp_wdata)
	);

	always #2 mclk = ~mclk;

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles > 3000)
		begin
			num_errors++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (num_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [63:0] raw(input logic [4:0] i);
		raw = {24'hF0E1D2, 3'h0, i, 32'h0000_1234 + {27'h0, i}};
	endfunction : raw

	// drop every bench-driven strobe (not the pipe's gp_we) at the next edge, then let outputs settle
	task automatic done;
		@(posedge mclk);
		{link_we, fp_we, pc_advance, branch_taken, jump_taken} <= '0;
		{upper_we, bottom_we, ll_set, ll_clear, fcsr_we, fcsr_hw_set} <= '0;
		#1;
	endtask : done

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk(pc, crf_pkg::PC_RESET);
		chk(product_upper_half, 64'h0);
		chk(product_bottom_half, 64'h0);
		chk({63'h0, load_link_flag}, 64'h0);
		chk({32'h0, float_control_status_reg}, {32'h0, crf_pkg::FCSR_RESET});
	endtask : t_reset

	task automatic t_gp;
		for (int i = 0; i < 32; i++)
		begin
			pipe.wr(5'(i), raw(5'(i)), i % 2, ra);
			chk(ra, (i == 0) ? 64'h0 : raw(5'(i)));
		end
		for (int i = 0; i < 32; i++)
		begin
			pipe.rd(5'(i), ~5'(i), ra, rb);
			chk(ra, (i == 0) ? 64'h0 : raw(5'(i)));
			chk(rb, (i == 31) ? 64'h0 : raw(~5'(i)));
		end
	endtask : t_gp

	task automatic t_gp32;
		@(posedge mclk);
		mode64 <= 1'b0;
		pipe.wr(5'h09, 64'h0000_0000_8000_0001, 0, ra);
		chk(ra, 64'hFFFF_FFFF_8000_0001);
		pipe.wr(5'h0A, 64'hFFFF_0000_1234_5678, 0, ra);
		chk(ra, 64'h0000_0000_1234_5678);
	endtask : t_gp32

	task automatic t_fp(input logic m, input logic [4:0] idx, input logic [63:0] d);
		@(posedge mclk);
		{mode64, fp_we, fp_waddr, fp_wdata, fp_raddr_a, fp_raddr_b} <= {m, 1'b1, idx, d, idx, idx};
		done();
		chk(fp_rdata_a, d);
		chk(fp_rdata_b, d);
		@(posedge mclk);
		#1;
		chk({52'h0, fp_exp_a}, {53'h0, d[62:52]});
	endtask : t_fp

	task automatic t_prod(input logic m, hw, lw, input logic [63:0] hd, ld, eh, el);
		@(posedge mclk);
		{mode64, upper_we, bottom_we, upper_wdata, bottom_wdata} <= {m, hw, lw, hd, ld};
		done();
		chk(product_upper_half, eh);
		chk(product_bottom_half, el);
	endtask : t_prod

	task automatic t_ll(input logic s, c, e);
		@(posedge mclk);
		{ll_set, ll_clear} <= {s, c};
		done();
		chk({63'h0, load_link_flag}, {63'h0, e});
	endtask : t_ll

	task automatic t_fc(input logic we, input logic [31:0] wd, hw, e);
		@(posedge mclk);
		{fcsr_we, fcsr_wdata, fcsr_hw_set} <= {we, wd, hw};
		done();
		chk({32'h0, float_control_status_reg}, {32'h0, e});
		chk({32'h0, float_impl_revision_reg}, {32'h0, crf_pkg::FPU_ID_VALUE});
	endtask : t_fc

	task automatic t_pc(input logic m, adv, br, jp, input logic [15:0] off,
		input logic [63:0] tgt, exp);
		@(posedge mclk);
		{mode64, pc_advance, branch_taken, jump_taken} <= {m, adv, br, jp};
		{branch_offset, jump_target} <= {off, tgt};
		done();
		chk(pc, exp);
	endtask : t_pc

	// link write and ordinary write to register 31 in the same cycle
	task automatic t_link;
		fork
			pipe.wr(5'h1F, 64'hDEAD_BEEF_0000_0001, 0, ra);
			begin
				@(posedge mclk);
				link_we <= 1'b1;
				done();
			end
		join
		pipe.rd(5'h1F, 5'h00, ra, rb);
		chk(ra, 64'h1234_5678_9ABC_DEF8);
		chk(rb, 64'h0);
	endtask : t_link

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		reset = 1'b1;
		mode64 = 1'b1;
		{link_we, pc_advance, branch_taken, jump_taken, upper_we, bottom_we} = '0;
		{ll_set, ll_clear, fcsr_we, fcsr_wdata, fcsr_hw_set, branch_offset} = '0;
		{fp_raddr_a, fp_raddr_b, fp_waddr, fp_wdata, jump_target, upper_wdata, bottom_wdata} = '0;
		// load float register zero while in reset so the watched read path holds no unknown
		fp_we = 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		fp_we <= 1'b0;
		#1;
		t_reset();
		t_gp();
		t_gp32();
		t_fp(1'b1, 5'h00, 64'h3FF8_0000_0000_0001);
		t_fp(1'b0, 5'h05, 64'h8123_4567_89AB_CDEF);
		pipe.rd(5'h05, 5'h00, ra, rb);
		chk(ra, raw(5'h05));
		t_prod(1, 1, 1, 64'h8765_4321_0FED_CBA9, 64'h0123_4567_89AB_CDEF,
			64'h8765_4321_0FED_CBA9, 64'h0123_4567_89AB_CDEF);
		t_prod(0, 1, 0, 64'h0000_0000_8000_0000, 64'h5555, 64'hFFFF_FFFF_8000_0000,
			64'h0123_4567_89AB_CDEF);
		t_prod(0, 0, 1, 64'h1, 64'h1111_1111_7FFF_FFFF, 64'hFFFF_FFFF_8000_0000,
			64'h0000_0000_7FFF_FFFF);
		t_ll(1, 0, 1);
		t_ll(0, 1, 0);
		t_ll(1, 1, 1);
		t_ll(0, 0, 1);
		t_ll(0, 1, 0);
		t_fc(1, 32'hFFFF_FFFF, 32'h0, 32'h01FF_FFFF);
		t_fc(1, 32'h0, 32'h0000_0040, 32'h0000_0040);
		t_fc(0, 32'h0, 32'h0000_0004, 32'h0000_0044);
		t_fc(1, 32'h0, 32'h0, 32'h0);
		t_pc(1, 1, 0, 0, 16'h0000, 64'h0, 64'h4);
		t_pc(1, 1, 0, 0, 16'hFFFE, 64'h0, 64'h8);
		t_pc(1, 1, 1, 0, 16'hFFFE, 64'h0, 64'h4);
		t_pc(1, 1, 1, 0, 16'h0003, 64'h0, 64'h14);
		t_pc(1, 1, 1, 1, 16'h0003, 64'h1234_5678_9ABC_DEF0, 64'h1234_5678_9ABC_DEF0);
		t_pc(1, 0, 1, 1, 16'h0003, 64'h0, 64'h1234_5678_9ABC_DEF0);
		t_link();
		t_pc(0, 1, 0, 1, 16'h0000, 64'h0000_0000_8000_0000, 64'hFFFF_FFFF_8000_0000);
		end_sim();
	end
endmodule : crf_core_tb_top
